// ---- bif_consts.svh ----
// Constants for the binary input filter and tap position decoder.
`ifndef BIF_CONSTS_SVH
`define BIF_CONSTS_SVH
`define BIF_CLK_HZ 125000000
`define BIF_TICK_MS 1
`define BIF_MS_PER_S 1000
`define BIF_TICK_CYCLES ((`BIF_CLK_HZ / `BIF_MS_PER_S) * `BIF_TICK_MS)
`define BIF_FILT_MAX_MS 86400000
`define BIF_FILT_W 27
`define BIF_POS_W 6
`define BIF_POS_MIN 6'h01
`define BIF_POS_MAX 6'h3E
`define BIF_POS_BAD 6'h3F
`define BIF_TAB_DEPTH 64
`define BIF_BCD_DIGIT_MAX 4'h9
`define BIF_BCD_TEN 8'h0A
`endif

// ---- bif_pkg.sv ----
// Types shared by the binary input filter and tap position decoder.
`default_nettype none
package bif_pkg;
	typedef enum logic [1:0] {
		BIF_ENC_BINARY = 2'b00,
		BIF_ENC_BCD    = 2'b01,
		BIF_ENC_ONE_N  = 2'b10,
		BIF_ENC_TABLE  = 2'b11
	} bif_enc_t;
	typedef enum logic [1:0] {
		BIF_ISP_OFF   = 2'b00,
		BIF_ISP_ON    = 2'b01,
		BIF_ISP_UNDEF = 2'b10
	} bif_isp_t;
endpackage
`default_nettype wire

// ---- bif_filter.sv ----
// One debounce channel timed by the shared millisecond tick.
`include "bif_consts.svh"
`default_nettype none
module bif_filter #(
	parameter int TW = `BIF_FILT_W
) (
	input  wire logic          sys_clk,
	input  wire logic          reset_n,
	input  wire logic          tick,
	input  wire logic          raw,
	input  wire logic [TW-1:0] filt_time,
	input  wire logic          retrigger,
	input  wire logic          hold,
	output logic               state
);
	logic          raw_q;
	logic          pending;
	logic [TW-1:0] count;
	logic          restart;
	logic          expired;

	assign restart = retrigger && (raw != raw_q);
	assign expired = (count >= filt_time);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			raw_q <= 1'b0;
		end else begin
			raw_q <= raw;
		end
	end

	// A return to the passed state cancels the interval, so a bounce that
	// settles back never reaches the output.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pending <= 1'b0;
			count   <= '0;
		end else if (raw == state) begin
			pending <= 1'b0;
			count   <= '0;
		end else if (!pending || restart) begin
			pending <= 1'b1;
			count   <= '0;
		end else if (tick && (count != {TW{1'b1}})) begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= 1'b0;
		end else if (!hold && (raw != state) && pending && !restart
				&& expired) begin
			state <= raw;
		end
	end
endmodule
`default_nettype wire

// ---- bif_top.sv ----
// Binary input filtering, two-bit position handling and tap decoding.
`include "bif_consts.svh"
`default_nettype none
module bif_top
	import bif_pkg::*;
#(
	parameter int N_IN        = 16,
	parameter int TW          = `BIF_FILT_W,
	parameter int TICK_CYCLES = `BIF_TICK_CYCLES
) (
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	input  wire logic [N_IN-1:0]   bin_in,
	input  wire logic [N_IN*TW-1:0] filt_time,
	input  wire logic [N_IN-1:0]   retrigger,
	input  wire logic [N_IN-1:0]   chatter_en,
	input  wire logic              chatter_block,
	input  wire logic [N_IN/2-1:0] pair_mode,
	input  wire logic [N_IN/2-1:0] pair_suppress,
	input  wire bif_pkg::bif_enc_t tap_enc,
	input  wire logic [7:0]        tap_first,
	input  wire logic [7:0]        tap_bits,
	input  wire logic [5:0]        tap_positions,
	input  wire logic [5:0]        tap_offset,
	input  wire logic [5:0]        tap_step,
	input  wire logic              tab_wr,
	input  wire logic [5:0]        tab_addr,
	input  wire logic [5:0]        tab_data,
	input  wire bif_pkg::bif_isp_t isp_reset_state,
	input  wire logic              isp_set,
	input  wire logic              isp_clr,
	input  wire logic [N_IN-1:0]   rec_sel,
	output logic [N_IN-1:0]        single_bit_indication,
	output logic [N_IN-1:0]        two_bit_position_indication,
	output logic [5:0]             tap_position_info,
	output bif_pkg::bif_isp_t      internal_single_bit_indication,
	output logic                   record_trig
);
	import bif_pkg::*;

	localparam int NP = N_IN / 2;
	localparam int CW = $clog2(TICK_CYCLES);
	localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

	logic [N_IN-1:0] sync_a;
	logic [N_IN-1:0] sync_b;
	logic [CW-1:0]   tick_cnt;
	logic            tick;
	logic [N_IN-1:0] filt;
	logic [N_IN-1:0] filt_q;
	logic [5:0]      tab_mem [`BIF_TAB_DEPTH];
	logic [N_IN-1:0] pattern;
	logic [5:0]      next_tap;
	logic            isp_init;

	// Field contacts are asynchronous to the core clock.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= bin_in;
			sync_b <= sync_a;
		end
	end

	// One tick serves every channel, so a channel costs only its counter.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else if (tick_cnt == TICK_LAST) begin
			tick_cnt <= '0;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			tick     <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi++) begin : g_ch
			bif_filter #(.TW(TW)) u_filt (
				.sys_clk   (sys_clk),
				.reset_n   (reset_n),
				.tick      (tick),
				.raw       (sync_b[gi]),
				.filt_time (filt_time[gi*TW +: TW]),
				.retrigger (retrigger[gi]),
				.hold      (chatter_en[gi] && chatter_block),
				.state     (filt[gi])
			);
		end
		for (gi = 0; gi < NP; gi++) begin : g_pair
			logic a;
			logic b;
			logic inter_raw;
			assign a = sync_b[2*gi];
			assign b = sync_b[2*gi+1];
			logic [TW-1:0] icnt;
			logic [1:0]    ab_q;
			logic          ihold;
			assign inter_raw = (a == b);
			assign ihold = chatter_en[2*gi] && chatter_block;
			// An end position clears the count at once, so only a lasting
			// intermediate position waits out the delay of the first bit.
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					ab_q <= 2'b00;
					icnt <= '0;
				end else begin
					ab_q <= {b, a};
					if (!inter_raw) begin
						icnt <= '0;
					end else if (retrigger[2*gi] && ({b, a} != ab_q)) begin
						icnt <= '0;
					end else if (tick && (icnt != {TW{1'b1}})) begin
						icnt <= icnt + 1'b1;
					end
				end
			end
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					two_bit_position_indication[2*gi +: 2] <= 2'b00;
				end else if (!pair_mode[gi] || !pair_suppress[gi]) begin
					two_bit_position_indication[2*gi +: 2] <=
						{filt[2*gi+1], filt[2*gi]};
				end else if (!inter_raw) begin
					two_bit_position_indication[2*gi +: 2] <= {b, a};
				end else if (!ihold
						&& (icnt >= filt_time[2*gi*TW +: TW])) begin
					two_bit_position_indication[2*gi +: 2] <= {b, a};
				end
			end
		end
		if (N_IN % 2 == 1) begin : g_odd
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					two_bit_position_indication[N_IN-1] <= 1'b0;
				end else begin
					two_bit_position_indication[N_IN-1] <= filt[N_IN-1];
				end
			end
		end
	endgenerate

	assign single_bit_indication = filt;

	// Capture pulse for the fault record on any selected output change.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			filt_q      <= '0;
			record_trig <= 1'b0;
		end else begin
			filt_q      <= filt;
			record_trig <= |((filt ^ filt_q) & rec_sel);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (tab_wr) begin
			tab_mem[tab_addr] <= tab_data;
		end
	end

	// Maps a 1-based code to a shown position, or to the unknown value.
	function automatic logic [5:0] bif_place(input logic [7:0] code,
			input logic [5:0] npos, input logic [5:0] offs,
			input logic [5:0] step);
		logic [15:0] p;
		p = 16'h0000;
		if ((code == 8'h00) || (code > {2'b00, npos})) begin
			bif_place = `BIF_POS_BAD;
		end else begin
			p = 16'({10'h000, offs}) + 16'({8'h00, code} - 16'h0001)
				* 16'({10'h000, step}) + 16'h0001;
			if ((p < 16'({10'h000, `BIF_POS_MIN}))
					|| (p > 16'({10'h000, `BIF_POS_MAX}))) begin
				bif_place = `BIF_POS_BAD;
			end else begin
				bif_place = p[5:0];
			end
		end
	endfunction

	// Consecutive inputs starting at the first one form the pattern.
	always_comb begin
		pattern = '0;
		for (int i = 0; i < N_IN; i++) begin
			if ((i < int'(tap_bits)) && (int'(tap_first) + i < N_IN)) begin
				pattern[i] = filt[int'(tap_first) + i];
			end
		end
	end

	always_comb begin
		logic [7:0] code;
		logic [7:0] ones;
		logic       bad;
		code = 8'h00;
		ones = 8'h00;
		bad  = 1'b0;
		next_tap = `BIF_POS_BAD;
		if ((tap_bits == 8'h00) || (int'(tap_bits) > N_IN)) begin
			bad = 1'b1;
		end
		case (tap_enc)
			BIF_ENC_BINARY: begin
				// An all-zero pattern gives code zero, hence unknown.
				code = 8'(pattern);
			end
			BIF_ENC_BCD: begin
				if ((pattern[3:0] > `BIF_BCD_DIGIT_MAX)
						|| (pattern[7:4] > `BIF_BCD_DIGIT_MAX)) begin
					bad = 1'b1;
				end
				code = 8'({4'h0, pattern[7:4]}) * `BIF_BCD_TEN
					+ 8'({4'h0, pattern[3:0]});
			end
			BIF_ENC_ONE_N: begin
				for (int i = 0; i < N_IN; i++) begin
					if (pattern[i]) begin
						ones = ones + 8'h01;
						code = 8'(i + 1);
					end
				end
				if (ones != 8'h01) begin
					bad = 1'b1;
				end
			end
			default: begin
				code = {2'b00, tab_mem[pattern[5:0]]};
				if ((code[5:0] == 6'h00) || (code[5:0] == `BIF_POS_BAD)) begin
					bad = 1'b1;
				end
			end
		endcase
		if (bad) begin
			next_tap = `BIF_POS_BAD;
		end else if (tap_enc == BIF_ENC_TABLE) begin
			next_tap = code[5:0];
		end else begin
			next_tap = bif_place(code, tap_positions, tap_offset,
				tap_step);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tap_position_info <= `BIF_POS_BAD;
		end else begin
			tap_position_info <= next_tap;
		end
	end

	// The configured state is loaded at the first edge after release,
	// since an asynchronous reset may only load a constant.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			isp_init                       <= 1'b0;
			internal_single_bit_indication <= BIF_ISP_UNDEF;
		end else if (!isp_init) begin
			isp_init                       <= 1'b1;
			internal_single_bit_indication <= isp_reset_state;
		end else if (isp_set) begin
			internal_single_bit_indication <= BIF_ISP_ON;
		end else if (isp_clr) begin
			internal_single_bit_indication <= BIF_ISP_OFF;
		end
	end
endmodule
`default_nettype wire

// ---- bif_contacts.sv ----
// Field contact model driving the binary inputs, with optional chatter.
`default_nettype none
module bif_contacts (
	input  wire logic       sys_clk,
	input  wire logic [7:0] level,
	input  wire logic [7:0] bounce,
	output logic      [7:0] bin_in = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flip = 1'b0;
	// Each contact has its own numbered line, so tap inputs run in order.
	// A bouncing contact toggles every cycle and is never stable.
	always @(posedge sys_clk) begin
		flip <= ~flip;
		bin_in <= level ^ (bounce & {8{flip}});
	end
endmodule
`default_nettype wire

// ---- bif_chk.sv ----
// Concurrent assertions on the ports of the filter and tap decoder.
`default_nettype none
module bif_chk
	import bif_pkg::*;
#(
	parameter int N_IN = 16
) (
	input wire logic              sys_clk,
	input wire logic              reset_n,
	input wire logic [N_IN-1:0]   bin_in,
	input wire logic [N_IN-1:0]   rec_sel,
	input wire logic [N_IN/2-1:0] pair_mode,
	input wire logic [N_IN/2-1:0] pair_suppress,
	input wire bif_pkg::bif_enc_t tap_enc,
	input wire logic [7:0]        tap_first,
	input wire logic [7:0]        tap_bits,
	input wire bif_pkg::bif_isp_t isp_reset_state,
	input wire logic              isp_set,
	input wire logic              isp_clr,
	input wire logic [N_IN-1:0]   single_bit_indication,
	input wire logic [N_IN-1:0]   two_bit_position_indication,
	input wire logic [5:0]        tap_position_info,
	input wire bif_pkg::bif_isp_t internal_single_bit_indication,
	input wire logic              record_trig
);
	import bif_pkg::*;
	wire logic [N_IN-1:0] s = single_bit_indication;
	wire logic [N_IN-1:0] p = two_bit_position_indication;
	wire logic [5:0]      t = tap_position_info;
	wire bif_isp_t        q = internal_single_bit_indication;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	single_follow_a: assert property (
		$changed(s[0]) |-> s[0] == $past(bin_in[0], 4))
		else $error("Single output does not match its settled input.");
	rec_trig_a: assert property (
		|((s ^ $past(s)) & rec_sel) |=> record_trig)
		else $error("Record trigger missing after a selected change.");
	tap_range_a: assert property (t != 6'h00)
		else $error("Tap position zero reported.");
	bin_zero_a: assert property (
		(tap_enc == BIF_ENC_BINARY && tap_first == 8'h00 &&
		 tap_bits == 8'h03 && s[2:0] == 3'h0) |=> t == 6'h3F)
		else $error("All-zero binary pattern not reported as unknown.");
	onen_bad_a: assert property (
		(tap_enc == BIF_ENC_ONE_N && tap_first == 8'h00 &&
		 tap_bits == 8'h04 && $countones(s[3:0]) != 1) |=> t == 6'h3F)
		else $error("Bad one-of-n pattern not reported as unknown.");
	isp_boot_a: assert property (
		$rose(reset_n) |=> q == $past(isp_reset_state))
		else $error("Internal indication missed its reset state.");
	isp_set_a: assert property (isp_set |=> q == BIF_ISP_ON)
		else $error("Internal indication not set.");
	isp_clr_a: assert property (
		isp_clr && !isp_set |=> q == BIF_ISP_OFF)
		else $error("Internal indication not cleared.");
	isp_hold_a: assert property (
		!isp_set && !isp_clr && $past(reset_n) |=> $stable(q))
		else $error("Internal indication changed without a request.");
	pair_end_a: assert property (
		(pair_mode[1] && pair_suppress[1] && $stable(bin_in[3:2]) &&
		 (bin_in[3] ^ bin_in[2]))[*4] |=> p[3:2] == $past(bin_in[3:2]))
		else $error("Defined pair position reported late.");
endmodule
bind bif_top bif_chk #(.N_IN(N_IN)) bif_chk_inst (
	.sys_clk, .reset_n, .bin_in, .rec_sel, .pair_mode, .pair_suppress,
	.tap_enc, .tap_first, .tap_bits, .isp_reset_state, .isp_set,
	.isp_clr, .single_bit_indication, .two_bit_position_indication,
	.tap_position_info, .internal_single_bit_indication, .record_trig
);
`default_nettype wire

// ---- bif_top_tb.sv ----
// Self-checking testbench for the filter and tap decoder.
`default_nettype none
`define BIF_CHK(a, b) begin \
	num_checks++; \
	if ((a) !== (b)) begin \
		err_total++; \
		$display("BAD %0t mismatch", $time); \
	end \
end
module bif_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bif_pkg::*;
	localparam int TW = 27;
	typedef struct packed {
		bif_enc_t   enc;
		logic [7:0] bits;
		logic [5:0] pos, off, step;
		logic [7:0] pat;
		logic [5:0] exp;
	} bif_row_t;
	bif_row_t rows [15] = '{
		'{BIF_ENC_BINARY, 8'h03, 6'h04, 6'h02, 6'h01, 8'h00, 6'h3F},
		'{BIF_ENC_BINARY, 8'h03, 6'h04, 6'h02, 6'h01, 8'h01, 6'h03},
		'{BIF_ENC_BINARY, 8'h03, 6'h04, 6'h02, 6'h01, 8'h02, 6'h04},
		'{BIF_ENC_BINARY, 8'h03, 6'h04, 6'h02, 6'h01, 8'h03, 6'h05},
		'{BIF_ENC_BINARY, 8'h03, 6'h04, 6'h02, 6'h01, 8'h04, 6'h06},
		'{BIF_ENC_BINARY, 8'h03, 6'h04, 6'h02, 6'h01, 8'h05, 6'h3F},
		'{BIF_ENC_BINARY, 8'h03, 6'h04, 6'h02, 6'h01, 8'h09, 6'h03},
		'{BIF_ENC_BINARY, 8'h00, 6'h04, 6'h02, 6'h01, 8'h01, 6'h3F},
		'{BIF_ENC_BINARY, 8'h03, 6'h04, 6'h00, 6'h02, 8'h03, 6'h05},
		'{BIF_ENC_BCD,    8'h08, 6'h14, 6'h00, 6'h01, 8'h12, 6'h0C},
		'{BIF_ENC_BCD,    8'h08, 6'h14, 6'h00, 6'h01, 8'h1A, 6'h3F},
		'{BIF_ENC_ONE_N,  8'h04, 6'h04, 6'h00, 6'h01, 8'h04, 6'h03},
		'{BIF_ENC_ONE_N,  8'h04, 6'h04, 6'h00, 6'h01, 8'h06, 6'h3F},
		'{BIF_ENC_TABLE,  8'h03, 6'h04, 6'h00, 6'h01, 8'h05, 6'h2A},
		'{BIF_ENC_TABLE,  8'h03, 6'h04, 6'h00, 6'h01, 8'h06, 6'h3F}
	};
	logic            sys_clk         = 1'b0;
	logic            reset_n         = 1'b0;
	logic [7:0]      level           = 8'h00;
	logic [7:0]      bounce          = 8'h00;
	logic [8*TW-1:0] filt_time       = '0;
	logic [7:0]      retrigger       = 8'h00;
	logic [7:0]      chatter_en      = 8'h00;
	logic            chatter_block   = 1'b0;
	logic [3:0]      pair_mode       = 4'h2;
	logic [3:0]      pair_suppress   = 4'h2;
	bif_enc_t        tap_enc         = BIF_ENC_BINARY;
	logic [7:0]      tap_first       = 8'h00;
	logic [7:0]      tap_bits        = 8'h03;
	logic [5:0]      tap_positions   = 6'h04;
	logic [5:0]      tap_offset      = 6'h02;
	logic [5:0]      tap_step        = 6'h01;
	logic            tab_wr          = 1'b0;
	logic [5:0]      tab_addr        = 6'h00;
	logic [5:0]      tab_data        = 6'h00;
	bif_isp_t        isp_reset_state = BIF_ISP_ON;
	logic            isp_set         = 1'b0;
	logic            isp_clr         = 1'b0;
	logic [7:0]      rec_sel         = 8'h01;
	logic [7:0]      bin_in, sbi, tbp;
	logic [5:0]      tap;
	bif_isp_t        isb;
	logic            record_trig;
	int              err_total       = 0;
	int              num_checks      = 0;
	always #4 sys_clk = ~sys_clk;
	bif_contacts bif_contacts_inst (.sys_clk, .level, .bounce, .bin_in);
	// A short tick keeps millisecond filter times within a brief run.
	bif_top #(.N_IN(8), .TICK_CYCLES(10)) bif_top_inst (
		.sys_clk, .reset_n, .bin_in, .filt_time, .retrigger, .chatter_en,
		.chatter_block, .pair_mode, .pair_suppress, .tap_enc, .tap_first,
		.tap_bits, .tap_positions, .tap_offset, .tap_step, .tab_wr,
		.tab_addr, .tab_data, .isp_reset_state, .isp_set, .isp_clr,
		.rec_sel, .single_bit_indication(sbi),
		.two_bit_position_indication(tbp), .tap_position_info(tap),
		.internal_single_bit_indication(isb), .record_trig
	);
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic do_reset(input bif_isp_t st);
		wt(1);
		reset_n <= 1'b0;
		isp_reset_state <= st;
		wt(20);
		@(negedge sys_clk);
		`BIF_CHK({sbi, tap, isb, record_trig}, {14'h003F, BIF_ISP_UNDEF, 1'b0})
		wt(1);
		reset_n <= 1'b1;
		wt(3);
		@(negedge sys_clk);
		`BIF_CHK(isb, st)
	endtask
	task automatic tab_put(input logic [5:0] a, input logic [5:0] d);
		wt(1);
		tab_wr <= 1'b1;
		tab_addr <= a;
		tab_data <= d;
		wt(1);
		tab_wr <= 1'b0;
	endtask
	initial begin
		#200000;
		err_total++;
		complete_run();
	end
	initial begin
		do_reset(BIF_ISP_ON);
		wt(1);
		isp_clr <= 1'b1;
		wt(1);
		isp_set <= 1'b1;
		wt(1);
		isp_set <= 1'b0;
		isp_clr <= 1'b0;
		@(negedge sys_clk);
		`BIF_CHK(isb, BIF_ISP_ON)
		// The table has no reset, so it is loaded before table decoding.
		tab_put(6'h05, 6'h2A);
		tab_put(6'h06, 6'h00);
		foreach (rows[i]) begin
			wt(1);
			tap_enc <= rows[i].enc;
			tap_bits <= rows[i].bits;
			tap_positions <= rows[i].pos;
			tap_offset <= rows[i].off;
			tap_step <= rows[i].step;
			level <= rows[i].pat;
			wt(10);
			@(negedge sys_clk);
			`BIF_CHK(sbi, rows[i].pat)
			`BIF_CHK(tap, rows[i].exp)
		end
		wt(1);
		level <= 8'h00;
		bounce[4] <= 1'b1;
		filt_time[2*TW+:TW] <= 27'd2;
		filt_time[4*TW+:TW] <= 27'd2;
		filt_time[6*TW+:TW] <= 27'd86400000;
		wt(40);
		@(negedge sys_clk);
		`BIF_CHK(sbi[4], 1'b0)
		for (int v = 1; v >= 0; v--) begin
			wt(1);
			bounce[4] <= 1'b0;
			level[4] <= 1'(v);
			level[6] <= 1'b1;
			wt(12);
			@(negedge sys_clk);
			`BIF_CHK(sbi[4], !1'(v))
			wt(30);
			@(negedge sys_clk);
			`BIF_CHK(sbi[4], 1'(v))
		end
		`BIF_CHK(sbi[6], 1'b0)
		wt(1);
		chatter_en[5] <= 1'b1;
		chatter_block <= 1'b1;
		level[7:5] <= 3'b111;
		wt(10);
		@(negedge sys_clk);
		`BIF_CHK(sbi[7:5], 3'b100)
		wt(1);
		chatter_block <= 1'b0;
		wt(6);
		@(negedge sys_clk);
		`BIF_CHK(sbi[5], 1'b1)
		for (int k = 0; k < 5; k++) begin
			logic [1:0] pv;
			// An intermediate position must not show before its delay.
			pv = 2'(8'h9D >> (2 * k));
			pv = (k == 1) ? 2'b01 : ((k == 4) ? 2'b10 : pv);
			wt(1);
			level[3:2] <= 2'(8'h9D >> (2 * k));
			wt(8);
			@(negedge sys_clk);
			`BIF_CHK(tbp[3:2], pv)
			if (k == 1) begin
				wt(40);
				@(negedge sys_clk);
				`BIF_CHK(tbp[3:2], 2'b11)
			end
		end
		do_reset(BIF_ISP_UNDEF);
		complete_run();
	end
endmodule
`undef BIF_CHK
`default_nettype wire
